// *** design/spd_defines.svh ***
`ifndef SPD_DEFINES_SVH
`define SPD_DEFINES_SVH
// Channel counts and FIFO depth
`define SPD_NRX 4
`define SPD_NCH 8
`define SPD_FIFO_DEPTH 3'd4
// Per-channel register index, address bits [2:0]
`define SPD_REG_CTRL 3'h0
`define SPD_REG_SEG 3'h1
`define SPD_REG_BASE 3'h2
`define SPD_REG_BOUND 3'h3
`define SPD_REG_PTR 3'h4
`define SPD_REG_BCNT 3'h5
`define SPD_REG_FCS 3'h6
`define SPD_REG_TMO 3'h7
// Shared registers
`define SPD_GLB_FLAGS 8'h80
`define SPD_GLB_MATCH 6'h21
// Control register fields, and the FCS register flush bit
`define SPD_CTRL_RUN 0
`define SPD_MODE_LO 1
`define SPD_MODE_HI 2
`define SPD_CTRL_IE 3
`define SPD_CTRL_CIRC 4
`define SPD_FCS_FLUSH 7
// Transmit header, high byte
`define SPD_HDR_LAST 7
// Timeout tick
`define SPD_CLK_MHZ 20
`define SPD_TICK_NS 1000
`define SPD_TICK_CYC ((`SPD_TICK_NS * `SPD_CLK_MHZ) / 1000)
`define SPD_RST_WORD 16'h0000
`endif

// *** design/spd_pkg.sv ***
package spd_pkg;
  typedef enum logic [1:0] {
    TXM_CHAIN = 2'b00,
    TXM_PKT = 2'b01,
    TXM_STOP = 2'b10,
    TXM_PER = 2'b11
  } spd_txm_e;
  typedef enum logic [1:0] {
    RXM_PKT = 2'b00,
    RXM_PER = 2'b01,
    RXM_TMO = 2'b10,
    RXM_MATCH = 2'b11
  } spd_rxm_e;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_HDR0 = 3'b001,
    ST_HDR1 = 3'b010,
    ST_TXRD = 3'b011,
    ST_RXWR = 3'b100,
    ST_PH0 = 3'b101,
    ST_PH1 = 3'b110
  } spd_st_e;
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [15:0] wdata;
  } spd_mmr_s;
  typedef struct packed {
    logic req;
    logic we;
    logic [23:0] addr;
    logic [7:0] wdata;
  } spd_mem_s;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic eop;
    logic abort;
  } spd_rx_s;
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] seg;
    logic [7:0] base;
    logic [15:0] bound;
    logic [15:0] ptr;
    logic [15:0] bcnt;
    logic [15:0] cnt;
    logic [13:0] pcnt;
    logic [7:0] tmo;
    logic [7:0] tmr;
    logic armed;
    logic last;
    logic [1:0] stat;
    logic [1:0] wp;
    logic [1:0] rp;
    logic [2:0] fill;
    logic [3:0][8:0] fifo;
  } spd_ch_s;
endpackage

// *** design/spd_dma_core.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "spd_defines.svh"

module spd_dma_core #(
  parameter int TICK_CYC = `SPD_TICK_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Register space
  input wire spd_pkg::spd_mmr_s mmr_i,
  output logic [15:0] mmr_rdata,
  // External memory
  output var spd_pkg::spd_mem_s mem_o,
  input wire logic mem_ack,
  input wire logic [7:0] mem_rdata,
  // Serial receivers
  input wire spd_pkg::spd_rx_s [3:0] rx_i,
  input wire logic [3:0] rx_autobaud_on,
  // Serial transmitters
  output logic [3:0] tx_valid,
  output logic [3:0][7:0] tx_data,
  input wire logic [3:0] tx_ready,
  // Channel events
  output logic [7:0] irq
);
  import spd_pkg::*;

  // ==========================================================
  // State
  spd_ch_s ch [8];
  spd_ch_s next_ch [8];
  logic [15:0] flags;
  logic [15:0] next_flags;
  logic [3:0][7:0] match;
  logic [3:0][7:0] next_match;
  spd_st_e st;
  spd_st_e next_st;
  logic [2:0] rr;
  logic [2:0] next_rr;
  logic [2:0] cur;
  logic [2:0] next_cur;
  logic [7:0] hdr;
  logic [7:0] next_hdr;
  spd_mem_s next_mem;
  logic [15:0] next_rdata;
  logic [15:0] tick;
  logic [15:0] next_tick;
  logic [7:0] need;
  logic [7:0] hdr_due;
  logic tick_hit;

  function automatic logic [15:0] spd_adv(input spd_ch_s c);
    logic [15:0] n;
    n = c.ptr + 16'h0001;
    if (c.ctrl[`SPD_CTRL_CIRC] && n == c.bound)
    begin
      n = {c.base, 8'h00};
    end
    return n;
  endfunction

  // ==========================================================
  // Per-channel request and serial outputs
  genvar g;
  generate
    for (g = 0; g < 8; g++)
    begin : g_ch
      if (g < `SPD_NRX)
      begin : g_rx
        assign hdr_due[g] = 1'b0;
        assign need[g] = ch[g].ctrl[`SPD_CTRL_RUN] && ch[g].fill != 3'd0;
        assign tx_valid[g] = ch[g+4].fill != 3'd0;
        assign tx_data[g] = ch[g+4].fifo[ch[g+4].rp][7:0];
      end
      else
      begin : g_tx
        // Chain modes drain fully before the next header is read
        assign hdr_due[g] = ch[g].ctrl[`SPD_CTRL_RUN] && !ch[g].ctrl[`SPD_MODE_HI] &&
          ch[g].cnt == 16'h0000 && ch[g].fill == 3'd0;
        assign need[g] = hdr_due[g] || (ch[g].ctrl[`SPD_CTRL_RUN] &&
          ch[g].cnt != 16'h0000 && ch[g].fill != `SPD_FIFO_DEPTH);
      end
    end
  endgenerate

  assign tick_hit = tick == TICK_CYC[15:0] - 16'h0001;

  always_comb
  begin
    logic [7:0] ev;
    logic [7:0] halt;
    logic [7:0] pop;
    logic [7:0] push_tx;
    logic [15:0] clr;
    logic [15:0] np;
    logic [13:0] pc;
    logic [2:0] wc;
    logic push;
    logic popv;
    logic tag;
    logic [8:0] din;
    ev = 8'h00;
    halt = 8'h00;
    pop = 8'h00;
    push_tx = 8'h00;
    clr = 16'h0000;
    np = 16'h0000;
    pc = 14'h0000;
    wc = mmr_i.addr[6:4];
    push = 1'b0;
    popv = 1'b0;
    tag = 1'b0;
    din = 9'h000;
    next_ch = ch;
    next_flags = flags;
    next_match = match;
    next_st = st;
    next_rr = rr;
    next_cur = cur;
    next_hdr = hdr;
    next_mem = mem_o;
    next_rdata = mmr_rdata;
    next_tick = tick_hit ? 16'h0000 : tick + 16'h0001;

    // ==========================================================
    // Register space access
    if (mmr_i.wr)
    begin
      if (mmr_i.addr == `SPD_GLB_FLAGS)
        clr = mmr_i.wdata;
      else if (mmr_i.addr[7:2] == `SPD_GLB_MATCH)
        next_match[mmr_i.addr[1:0]] = mmr_i.wdata[7:0];
      else if (!mmr_i.addr[7] && !mmr_i.addr[3])
      begin
        case (mmr_i.addr[2:0])
          `SPD_REG_CTRL:
          begin
            next_ch[wc].ctrl = mmr_i.wdata[7:0];
            // A chain start always begins with a header fetch
            if (wc[2] && !mmr_i.wdata[`SPD_MODE_HI] && !ch[wc].ctrl[`SPD_CTRL_RUN])
              next_ch[wc].cnt = 16'h0000;
          end
          `SPD_REG_SEG: next_ch[wc].seg = mmr_i.wdata[7:0];
          `SPD_REG_BASE: next_ch[wc].base = mmr_i.wdata[7:0];
          `SPD_REG_BOUND: next_ch[wc].bound = mmr_i.wdata;
          `SPD_REG_PTR: next_ch[wc].ptr = mmr_i.wdata;
          `SPD_REG_BCNT:
          begin
            next_ch[wc].bcnt = mmr_i.wdata;
            // A running chain keeps the count taken from its header
            if (!(wc[2] && !ch[wc].ctrl[`SPD_MODE_HI] && ch[wc].ctrl[`SPD_CTRL_RUN]))
              next_ch[wc].cnt = mmr_i.wdata;
          end
          `SPD_REG_FCS:
          begin
            if (mmr_i.wdata[`SPD_FCS_FLUSH])
            begin
              next_ch[wc].wp = 2'b00;
              next_ch[wc].rp = 2'b00;
              next_ch[wc].fill = 3'd0;
            end
          end
          `SPD_REG_TMO: next_ch[wc].tmo = wc[2] ? 8'h00 : mmr_i.wdata[7:0];
          default: next_ch[wc].ctrl = ch[wc].ctrl;
        endcase
      end
    end
    if (mmr_i.rd)
    begin
      next_rdata = 16'h0000;
      if (mmr_i.addr == `SPD_GLB_FLAGS)
        next_rdata = flags;
      else if (mmr_i.addr[7:2] == `SPD_GLB_MATCH)
        next_rdata = {8'h00, match[mmr_i.addr[1:0]]};
      else if (!mmr_i.addr[7] && !mmr_i.addr[3])
      begin
        case (mmr_i.addr[2:0])
          `SPD_REG_CTRL: next_rdata = {8'h00, ch[wc].ctrl};
          `SPD_REG_SEG: next_rdata = {8'h00, ch[wc].seg};
          `SPD_REG_BASE: next_rdata = {8'h00, ch[wc].base};
          `SPD_REG_BOUND: next_rdata = ch[wc].bound;
          `SPD_REG_PTR: next_rdata = ch[wc].ptr;
          `SPD_REG_BCNT: next_rdata = ch[wc].bcnt;
          `SPD_REG_FCS: next_rdata = {9'h000, ch[wc].rp, ch[wc].fill, ch[wc].fill == `SPD_FIFO_DEPTH,
            ch[wc].fill == 3'd0};
          `SPD_REG_TMO: next_rdata = {8'h00, ch[wc].tmo};
          default: next_rdata = 16'h0000;
        endcase
      end
    end

    // ==========================================================
    // Memory engine, one transfer at a time
    np = spd_adv(ch[cur]);
    case (st)
      ST_IDLE:
      begin
        next_mem.req = 1'b0;
        next_rr = rr + 3'd1;
        if (need[rr])
        begin
          next_cur = rr;
          next_mem.req = 1'b1;
          next_mem.addr = {ch[rr].seg, ch[rr].ptr};
          next_mem.we = !rr[2];
          next_mem.wdata = ch[rr].fifo[ch[rr].rp][7:0];
          next_st = !rr[2] ? ST_RXWR : (hdr_due[rr] ? ST_HDR0 : ST_TXRD);
        end
      end
      ST_HDR0:
      begin
        if (mem_ack)
        begin
          next_hdr = mem_rdata;
          next_ch[cur].ptr = np;
          next_mem.addr = {ch[cur].seg, np};
          next_st = ST_HDR1;
        end
      end
      ST_HDR1:
      begin
        if (mem_ack)
        begin
          next_ch[cur].ptr = np;
          next_mem.req = 1'b0;
          next_st = ST_IDLE;
          next_ch[cur].cnt = {2'b00, mem_rdata[5:0], hdr};
          next_ch[cur].last = mem_rdata[`SPD_HDR_LAST];
          if (ch[cur].ctrl[`SPD_MODE_LO] && ch[cur].last)
            ev[cur] = 1'b1;
          if (mem_rdata[5:0] == 6'h00 && hdr == 8'h00)
          begin
            next_ch[cur].ctrl[`SPD_CTRL_RUN] = 1'b0;
            halt[cur] = 1'b1;
            if (!ch[cur].ctrl[`SPD_MODE_LO])
              ev[cur] = 1'b1;
          end
        end
      end
      ST_TXRD:
      begin
        if (mem_ack)
        begin
          push_tx[cur] = 1'b1;
          next_ch[cur].ptr = np;
          next_ch[cur].cnt = ch[cur].cnt - 16'h0001;
          if (ch[cur].cnt == 16'h0001 && ch[cur].ctrl[`SPD_MODE_HI:`SPD_MODE_LO] == TXM_PER)
          begin
            next_ch[cur].cnt = ch[cur].bcnt;
            ev[cur] = 1'b1;
          end
          next_mem.req = 1'b0;
          next_st = ST_IDLE;
        end
      end
      ST_RXWR:
      begin
        if (mem_ack)
        begin
          pop[cur] = 1'b1;
          next_ch[cur].ptr = np;
          pc = ch[cur].pcnt + 14'h0001;
          next_ch[cur].pcnt = pc;
          tag = ch[cur].fifo[ch[cur].rp][8];
          next_mem.req = 1'b0;
          next_st = ST_IDLE;
          case (ch[cur].ctrl[`SPD_MODE_HI:`SPD_MODE_LO])
            RXM_PER:
            begin
              next_ch[cur].cnt = ch[cur].cnt - 16'h0001;
              if (ch[cur].cnt == 16'h0001)
              begin
                next_ch[cur].cnt = ch[cur].bcnt;
                ev[cur] = 1'b1;
              end
            end
            RXM_MATCH: ev[cur] = tag;
            RXM_PKT:
            begin
              if (tag)
              begin
                next_mem.req = 1'b1;
                next_mem.addr = {ch[cur].seg, np};
                next_mem.wdata = pc[7:0];
                next_st = ST_PH0;
              end
            end
            default: tag = 1'b0;
          endcase
        end
      end
      ST_PH0:
      begin
        if (mem_ack)
        begin
          next_ch[cur].ptr = np;
          next_mem.addr = {ch[cur].seg, np};
          next_mem.wdata = {ch[cur].stat, ch[cur].pcnt[13:8]};
          next_st = ST_PH1;
        end
      end
      ST_PH1:
      begin
        if (mem_ack)
        begin
          next_ch[cur].ptr = np;
          next_ch[cur].pcnt = 14'h0000;
          next_mem.req = 1'b0;
          next_st = ST_IDLE;
          ev[cur] = 1'b1;
        end
      end
      default:
      begin
        next_mem.req = 1'b0;
        next_st = ST_IDLE;
      end
    endcase

    // ==========================================================
    // Channel FIFOs, timers and serial side
    for (int c = 0; c < 8; c++)
    begin
      push = 1'b0;
      popv = 1'b0;
      din = 9'h000;
      if (c < `SPD_NRX)
      begin
        if (rx_autobaud_on[c])
          next_ch[c].ctrl[`SPD_CTRL_RUN] = 1'b1;
        popv = pop[c] && next_ch[c].fill != 3'd0;
        if (rx_i[c].valid)
        begin
          // Overrun bytes are dropped; software sees a full FIFO
          push = next_ch[c].ctrl[`SPD_CTRL_RUN] && next_ch[c].fill != `SPD_FIFO_DEPTH;
          din[7:0] = rx_i[c].data;
          case (next_ch[c].ctrl[`SPD_MODE_HI:`SPD_MODE_LO])
            RXM_MATCH: din[8] = rx_i[c].data == match[0] || rx_i[c].data == match[1] ||
              rx_i[c].data == match[2] || rx_i[c].data == match[3];
            RXM_PKT: din[8] = rx_i[c].eop;
            default: din[8] = 1'b0;
          endcase
          if (rx_i[c].eop && push)
            next_ch[c].stat = {1'b0, rx_i[c].abort};
          next_ch[c].tmr = ch[c].tmo;
          next_ch[c].armed = 1'b1;
        end
        else if (ch[c].armed && tick_hit &&
          ch[c].ctrl[`SPD_MODE_HI:`SPD_MODE_LO] == RXM_TMO)
        begin
          next_ch[c].tmr = ch[c].tmr - 8'h01;
          if (ch[c].tmr <= 8'h01)
          begin
            next_ch[c].armed = 1'b0;
            ev[c] = 1'b1;
          end
        end
      end
      else
      begin
        popv = tx_valid[c%4] && tx_ready[c%4];
        push = push_tx[c];
        din = {1'b0, mem_rdata};
        if (ch[c].ctrl[`SPD_CTRL_RUN] && ch[c].ctrl[`SPD_MODE_HI:`SPD_MODE_LO] == TXM_STOP &&
          ch[c].cnt == 16'h0000 && ch[c].fill == 3'd0 && st != ST_TXRD)
        begin
          next_ch[c].ctrl[`SPD_CTRL_RUN] = 1'b0;
          halt[c] = 1'b1;
          ev[c] = 1'b1;
        end
      end
      if (push)
      begin
        next_ch[c].fifo[next_ch[c].wp] = din;
        next_ch[c].wp = next_ch[c].wp + 2'b01;
      end
      if (popv)
        next_ch[c].rp = next_ch[c].rp + 2'b01;
      if (push && !popv)
        next_ch[c].fill = next_ch[c].fill + 3'd1;
      else if (popv && !push)
        next_ch[c].fill = next_ch[c].fill - 3'd1;
    end
    // Set wins over a clear in the same cycle
    next_flags = (flags & ~clr) | {halt, ev};
  end

  always_comb
  begin
    for (int c = 0; c < 8; c++)
      irq[c] = flags[c] && ch[c].ctrl[`SPD_CTRL_IE];
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ch <= '{default: '0};
      flags <= `SPD_RST_WORD;
      match <= '0;
      st <= ST_IDLE;
      rr <= 3'd0;
      cur <= 3'd0;
      hdr <= 8'h00;
      mem_o <= '0;
      mmr_rdata <= `SPD_RST_WORD;
      tick <= `SPD_RST_WORD;
    end
    else
    begin
      ch <= next_ch;
      flags <= next_flags;
      match <= next_match;
      st <= next_st;
      rr <= next_rr;
      cur <= next_cur;
      hdr <= next_hdr;
      mem_o <= next_mem;
      mmr_rdata <= next_rdata;
      tick <= next_tick;
    end
  end
endmodule
`default_nettype wire

// *** bench/spd_dma_core_asserts.sv ***
`timescale 1ns/100ps
`default_nettype none
// ==========
// Port checks
module spd_dma_core_asserts #(
  parameter int TICK_CYC = 20
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Register space
  input wire spd_pkg::spd_mmr_s mmr_i,
  input wire logic [15:0] mmr_rdata,
  // Memory and serial
  input wire spd_pkg::spd_mem_s mem_o,
  input wire logic mem_ack,
  input wire logic [3:0] tx_valid,
  input wire logic [3:0][7:0] tx_data,
  input wire logic [3:0] tx_ready,
  input wire logic [7:0] irq
);
  import spd_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_seg_rw;
    mmr_i.wr && mmr_i.addr == 8'h01 ##2 mmr_i.rd && mmr_i.addr == 8'h01;
  endsequence
  sequence s_tmo_tx_rw;
    mmr_i.wr && mmr_i.addr == 8'h47 ##2 mmr_i.rd && mmr_i.addr == 8'h47;
  endsequence
  a_rd_hold: assert property (
    !mmr_i.rd |=> $stable(mmr_rdata)) else $error("read data moved without a read");
  a_req_hold: assert property (
    mem_o.req && !mem_ack |=> mem_o.req && $stable(mem_o)) else $error("memory request changed before ack");
  for (genvar p = 0; p < 4; p++)
  begin : g_tx
    a_tx_hold: assert property (
      tx_valid[p] && !tx_ready[p] |=> tx_valid[p] && $stable(tx_data[p]))
      else $error("transmit byte withdrawn before taken");
  end
  a_reset_quiet: assert property (
    $fell(rst) |-> !mem_o.req && tx_valid == 4'h0 && irq == 8'h00) else $error("outputs busy after reset");
  a_unmapped_rd: assert property (
    mmr_i.rd && mmr_i.addr == 8'h08 |=> mmr_rdata == 16'h0000) else $error("unmapped read not zero");
  a_ie_mask: assert property (
    mmr_i.wr && !mmr_i.addr[7] && mmr_i.addr[3:0] == 4'h0 && !mmr_i.wdata[3] |=> !irq[$past(mmr_i.addr[6:4])])
    else $error("interrupt shown while disabled");
  a_seg_readback: assert property (
    s_seg_rw |=> mmr_rdata == {8'h00, $past(mmr_i.wdata[7:0], 3)}) else $error("segment read back wrong");
  a_tmo_tx_zero: assert property (
    s_tmo_tx_rw |=> mmr_rdata == 16'h0000) else $error("transmit channel holds a timeout");
endmodule
bind spd_dma_core spd_dma_core_asserts #(.TICK_CYC(TICK_CYC)) u_asserts (.clk_sys(clk_sys), .rst(rst),
  .mmr_i(mmr_i), .mmr_rdata(mmr_rdata), .mem_o(mem_o), .mem_ack(mem_ack), .tx_valid(tx_valid),
  .tx_data(tx_data), .tx_ready(tx_ready), .irq(irq));
`default_nettype wire

// *** bench/spd_far_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// ==========
// Byte memory and four serial transmitters
module spd_far_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Memory port
  input wire spd_pkg::spd_mem_s mem_i,
  output logic mem_ack,
  output logic [7:0] mem_rdata,
  input wire logic [3:0] lat,
  // Serial transmitters
  input wire logic [3:0] tx_valid,
  input wire logic [3:0][7:0] tx_data,
  output logic [3:0] tx_ready
);
  import spd_pkg::*;
  logic [7:0] mem [logic [23:0]];
  logic [7:0] txq [4][$];
  logic [3:0] wcnt;
  logic [7:0] last;
  logic [2:0] phase;
  // Released bus shows the inverse, never a stale copy
  assign mem_rdata = mem_ack ? last : ~last;
  // One stall in eight keeps the hold path busy
  assign tx_ready = (phase == 3'h3) ? 4'h0 : 4'hF;
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      mem_ack <= 1'b0;
      wcnt <= 4'h0;
      phase <= 3'h0;
      last <= 8'h00;
    end
    else
    begin
      phase <= phase + 3'h1;
      for (int p = 0; p < 4; p++)
        if (tx_valid[p] && tx_ready[p])
          txq[p].push_back(tx_data[p]);
      mem_ack <= 1'b0;
      if (mem_i.req && !mem_ack)
      begin
        wcnt <= wcnt + 4'h1;
        if (wcnt >= lat)
        begin
          wcnt <= 4'h0;
          mem_ack <= 1'b1;
          if (mem_i.we)
            mem[mem_i.addr] = mem_i.wdata;
          else
            last <= mem.exists(mem_i.addr) ? mem[mem_i.addr] : 8'hEE;
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** bench/serial_port_dma_controller_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
module serial_port_dma_controller_bench;
  import spd_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  spd_mmr_s memory_mapped_register_space = '0;
  logic [15:0] mmr_rdata;
  spd_mem_s mem;
  logic mem_ack;
  logic [7:0] mem_rdata;
  spd_rx_s [3:0] rx = '0;
  logic [3:0] abaud = 4'h0;
  logic [3:0] lat = 4'h0;
  logic [3:0] tx_valid;
  logic [3:0][7:0] tx_data;
  logic [3:0] tx_ready;
  logic [7:0] irq;
  logic [15:0] v;
  // Fragment header, byte, zero header, last header, byte, zero header
  logic [79:0] pkt = 80'h0000_E280_0100_00E1_0001;
  int n_fail = 0;
  int n_checks = 0;
  // Address, write value, read-back value
  logic [39:0] rows [10] = '{40'h01_12AB_00AB, 40'h02_0155_0055, 40'h03_BEEF_BEEF, 40'h05_1234_1234,
    40'h07_00A5_00A5, 40'h47_00A5_0000, 40'h08_FFFF_0000, 40'h84_0041_0041, 40'h74_CAFE_CAFE,
    40'h60_001E_001E};
  always #25 clk_sys = ~clk_sys;
  spd_dma_core #(.TICK_CYC(2)) u_dut (.clk_sys(clk_sys), .rst(rst), .mmr_i(memory_mapped_register_space), .mmr_rdata(mmr_rdata),
    .mem_o(mem), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .rx_i(rx), .rx_autobaud_on(abaud),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .irq(irq));
  spd_far_model u_far (.clk_sys(clk_sys), .rst(rst), .mem_i(mem), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .lat(lat), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
  // ==========
  // Tasks
  task automatic wrap_up();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk_sys);
    memory_mapped_register_space.wr = 1'b1;
    memory_mapped_register_space.addr = a;
    memory_mapped_register_space.wdata = d;
    @(negedge clk_sys);
    memory_mapped_register_space.wr = 1'b0;
  endtask
  task automatic chk_reg(input logic [7:0] a, input logic [15:0] e);
    @(negedge clk_sys);
    memory_mapped_register_space.rd = 1'b1;
    memory_mapped_register_space.addr = a;
    @(negedge clk_sys);
    memory_mapped_register_space.rd = 1'b0;
    v = mmr_rdata;
    chk($sformatf("register %h", a), e, v);
  endtask
  task automatic rx_send(input int p, input logic [7:0] d, input logic e);
    @(negedge clk_sys);
    rx[p] = {1'b1, d, e, 1'b0};
    @(negedge clk_sys);
    rx[p] = '0;
    repeat (8) @(negedge clk_sys);
  endtask
  task automatic wait_irq(input int c, input int lim);
    for (int k = 0; k < lim; k++)
    begin
      @(negedge clk_sys);
      if (irq[c] === 1'b1)
        break;
    end
    chk("irq line", 16'h0001, {15'h0000, irq[c]});
  endtask
  task automatic chk_tx(input int p, input logic [31:0] e, input int n);
    chk("tx count", 16'(n), 16'(u_far.txq[p].size()));
    for (int i = 0; i < n; i++)
      chk("tx byte", {8'h00, e[8*i+:8]}, {8'h00, u_far.txq[p][i]});
  endtask
  function automatic logic [15:0] mv(input logic [23:0] a);
    return u_far.mem.exists(a) ? {8'h00, u_far.mem[a]} : 16'hFFFF;
  endfunction
  // ==========
  // Watchdog, well beyond the few hundred cycles needed
  initial
  begin
    #1000000;
    n_fail++;
    wrap_up();
  end
  // ==========
  // Sequence
  initial
  begin
    repeat (8) @(negedge clk_sys);
    rst = 1'b0;
    chk_reg(8'h00, 16'h0000);
    chk_reg(8'h80, 16'h0000);
    chk("irq reset", 16'h0000, {8'h00, irq});
    chk("tx_valid reset", 16'h0000, {12'h000, tx_valid});
    for (int i = 0; i < 10; i++)
    begin
      reg_wr(rows[i][39:32], rows[i][31:16]);
      chk_reg(rows[i][39:32], rows[i][15:0]);
    end
    for (int i = 0; i < 3; i++)
      u_far.mem[24'h120010 + 24'(i)] = 8'hA1 + 8'(i);
    reg_wr(8'h41, 16'h0012);
    reg_wr(8'h44, 16'h0010);
    reg_wr(8'h45, 16'h0003);
    reg_wr(8'h40, 16'h000D);
    wait_irq(4, 300);
    chk_tx(0, 32'h00A3A2A1, 3);
    chk_reg(8'h80, 16'h1010);
    chk_reg(8'h40, 16'h000C);
    reg_wr(8'h80, 16'hFFFF);
    chk_reg(8'h80, 16'h0000);
    u_far.mem[24'h000500] = 8'h02;
    u_far.mem[24'h000501] = 8'h00;
    u_far.mem[24'h000502] = 8'hB1;
    u_far.mem[24'h000503] = 8'hB2;
    u_far.mem[24'h000504] = 8'h00;
    u_far.mem[24'h000505] = 8'h00;
    reg_wr(8'h54, 16'h0500);
    reg_wr(8'h55, 16'h0009);
    reg_wr(8'h50, 16'h0009);
    wait_irq(5, 300);
    chk_tx(1, 32'h0000B2B1, 2);
    reg_wr(8'h80, 16'hFFFF);
    // Slow memory for the channel 0 receive tests
    lat = 4'h3;
    reg_wr(8'h01, 16'h0000);
    reg_wr(8'h02, 16'h0002);
    reg_wr(8'h03, 16'h0203);
    reg_wr(8'h04, 16'h0200);
    reg_wr(8'h05, 16'h0002);
    reg_wr(8'h00, 16'h001B);
    rx_send(0, 8'h11, 1'b0);
    rx_send(0, 8'h22, 1'b0);
    wait_irq(0, 100);
    reg_wr(8'h80, 16'h0001);
    rx_send(0, 8'h33, 1'b0);
    chk("irq mid count", 16'h0000, {15'h0000, irq[0]});
    rx_send(0, 8'h44, 1'b0);
    wait_irq(0, 100);
    chk("mem 200", 16'h0044, mv(24'h000200));
    chk("mem 202", 16'h0033, mv(24'h000202));
    chk_reg(8'h04, 16'h0201);
    reg_wr(8'h00, 16'h001A);
    rx_send(0, 8'h55, 1'b0);
    chk_reg(8'h04, 16'h0201);
    lat = 4'h0;
    reg_wr(8'h17, 16'h0003);
    reg_wr(8'h14, 16'h0300);
    reg_wr(8'h10, 16'h000D);
    rx_send(1, 8'h66, 1'b0);
    wait_irq(1, 60);
    reg_wr(8'h24, 16'h0400);
    reg_wr(8'h20, 16'h000F);
    rx_send(2, 8'h30, 1'b0);
    chk("irq no match", 16'h0000, {15'h0000, irq[2]});
    rx_send(2, 8'h41, 1'b0);
    wait_irq(2, 60);
    chk("mem 401", 16'h0041, mv(24'h000401));
    @(negedge clk_sys);
    abaud = 4'h8;
    @(negedge clk_sys);
    abaud = 4'h0;
    chk_reg(8'h30, 16'h0001);
    reg_wr(8'h34, 16'h0600);
    reg_wr(8'h30, 16'h0009);
    rx_send(3, 8'hC1, 1'b0);
    rx_send(3, 8'hC2, 1'b1);
    wait_irq(3, 100);
    chk("trailer lo", 16'h0002, mv(24'h000602));
    chk("trailer hi", 16'h0000, mv(24'h000603));
    reg_wr(8'h30, 16'h0001);
    chk("irq masked", 16'h0000, {15'h0000, irq[3]});
    chk_reg(8'h80, 16'h000F);
    // Periodic transmit over a two-byte circular buffer
    u_far.mem[24'h000700] = 8'hD1;
    u_far.mem[24'h000701] = 8'hD2;
    reg_wr(8'h62, 16'h0007);
    reg_wr(8'h63, 16'h0702);
    reg_wr(8'h64, 16'h0700);
    reg_wr(8'h65, 16'h0002);
    reg_wr(8'h60, 16'h001F);
    wait_irq(6, 100);
    reg_wr(8'h80, 16'h0040);
    wait_irq(6, 100);
    reg_wr(8'h60, 16'h001E);
    repeat (20) @(negedge clk_sys);
    for (int i = 0; i < 4; i++)
      chk("tx periodic", {8'h00, 8'hD1 + 8'(i % 2)}, {8'h00, u_far.txq[2][i]});
    // Packet chain: a lone fragment stops quietly, a full packet interrupts
    for (int i = 0; i < 10; i++)
      u_far.mem[24'h000800 + 24'(i)] = pkt[8*i+:8];
    reg_wr(8'h74, 16'h0800);
    reg_wr(8'h70, 16'h000B);
    repeat (60) @(negedge clk_sys);
    chk("irq fragment", 16'h0000, {15'h0000, irq[7]});
    chk_reg(8'h70, 16'h000A);
    reg_wr(8'h70, 16'h000B);
    wait_irq(7, 300);
    chk_tx(3, 32'h0000E2E1, 2);
    wrap_up();
  end
endmodule
`default_nettype wire
